// [inc/sram_port_pkg.sv]
// Shared constants and carrier types of the burst SRAM port
package sram_port_pkg;
	localparam int ADDR_W = 18;
	localparam int LANES = 4;
	localparam int LANE_W = 9;
	localparam int DATA_W = LANES * LANE_W;
	localparam int BURST_W = 2;
	localparam int SLEEP_ENTER_CYC = 2;
	localparam int SLEEP_EXIT_CYC = 2;
	localparam logic [1:0] SLEEP_CNT_ZERO = 2'h0;
	localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;

	// Synchronous control pins sampled each edge
	typedef struct packed {
		logic first_chip_select_n;
		logic second_chip_select;
		logic third_chip_select_n;
		logic processor_addr_strobe_n;
		logic controller_addr_strobe_n;
		logic burst_advance_n;
		logic global_write_n;
		logic byte_write_enable_n;
		logic [LANES-1:0] byte_lane_select_n;
	} bus_ctrl_t;

	typedef enum logic {
		ORDER_LINEAR,
		ORDER_INTERLEAVED
	} burst_order_t;
endpackage

// [rtl/burst_counter.sv]
// Two-bit wraparound burst address generator
module burst_counter
	import sram_port_pkg::*;
(
	// Clock
	input wire logic i_clk,
	// Control
	input wire logic i_load,
	input wire logic i_step,
	input wire logic i_interleaved,
	input wire logic [BURST_W-1:0] i_start,
	// Address
	output logic [BURST_W-1:0] o_addr
);
	logic [BURST_W-1:0] start_reg;
	logic [BURST_W-1:0] count_reg;
	logic [BURST_W-1:0] count_next;

	// Next count: an advance cycle already uses the next address
	always_comb begin
		if (i_step)
			count_next = count_reg + 2'h1;
		else
			count_next = count_reg;
	end

	// Start value and step count
	always_ff @(posedge i_clk) begin
		if (i_load) begin
			start_reg <= i_start;
			count_reg <= BURST_ZERO;
		end else begin
			count_reg <= count_next;
		end
	end

	// Order select: xor or modular add
	always_comb begin
		if (i_interleaved)
			o_addr = start_reg ^ count_next;
		else
			o_addr = start_reg + count_next;
	end
endmodule

// [rtl/sram_core.sv]
// Byte-lane memory array with registered read port
module sram_core
	import sram_port_pkg::*;
#(
	parameter int AW = ADDR_W
)
(
	// Clock
	input wire logic i_clk,
	// Write port
	input wire logic [LANES-1:0] i_lane_we,
	input wire logic [AW-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_wdata,
	// Read port
	output logic [DATA_W-1:0] o_rdata
);
	logic [DATA_W-1:0] mem [0:(1<<AW)-1];

	// One write process per lane
	for (genvar l = 0; l < LANES; l++) begin : g_lane
		always_ff @(posedge i_clk) begin
			if (i_lane_we[l])
				mem[i_addr][l*LANE_W +: LANE_W] <=
					i_wdata[l*LANE_W +: LANE_W];
		end
	end

	// Registered read of the presented address
	always_ff @(posedge i_clk) begin
		o_rdata <= mem[i_addr];
	end
endmodule

// [rtl/sync_burst_sram_port.sv]
// Synchronous flow-through burst SRAM access logic
// Contract
// - Register every synchronous input on rising edge
// - Either address strobe starts an access
// - Mode low linear, high interleaved
// - Interleaved: start xor burst count
// - Linear: previous address plus one mod four
// - Counter steps only under burst advance
// - Byte writes gated by enable and selects
// - Global write writes all four lanes
// - Read needs all selects; processor strobe needs select; here only a start needs them, burst continue reads ignore the selects
// - Read data driven after edge, flow-through
// - Processor start ignores write inputs first cycle
// - Write data taken on edge after processor start
// - Controller strobe with write inputs writes immediately
// - Processor strobe low overrides controller strobe; here only while first select is low
// - Data pins released on any write cycle
// - Asynchronous sleep request keeps stored data
// - Two cycles to enter and leave sleep
// - Pending accesses at sleep entry are dropped
// - Write when global or enabled lane select low
// - Advance low steps, high suspends burst
// - Processor strobe start is always a read
module sync_burst_sram_port
	import sram_port_pkg::*;
#(
	parameter int AW = ADDR_W
)
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// Synchronous bus
	input wire bus_ctrl_t i_ctrl,
	input wire logic [AW-1:0] i_addr,
	input wire logic i_burst_order,
	// Asynchronous pins
	input wire logic i_output_enable_n,
	input wire logic i_sleep_request,
	// Common data pins
	input wire logic [DATA_W-1:0] i_dq,
	output logic [DATA_W-1:0] o_dq,
	output logic o_dq_oe_n,
	// Status
	output logic o_asleep
);
	// Refuse widths the logic cannot serve

	// The counter needs at least one upper address bit above it
	if (AW < BURST_W + 1) begin : g_aw_check
		$error("address too narrow for burst counter");
	end

	// The array is sized for a word address of at most this width
	if (AW > ADDR_W) begin : g_aw_max_check
		$error("address wider than the array supports");
	end

	// Lanes must tile the data word exactly
	if (LANES * LANE_W != DATA_W) begin : g_lane_check
		$error("lane split does not cover the data word");
	end

	// Sleep counts must fit the two-bit sleep counter
	if (SLEEP_ENTER_CYC < 1 || SLEEP_ENTER_CYC > 4) begin : g_enter_check
		$error("sleep entry count out of counter range");
	end

	if (SLEEP_EXIT_CYC < 1 || SLEEP_EXIT_CYC > 4) begin : g_exit_check
		$error("sleep exit count out of counter range");
	end

	// Registered pin samples
	bus_ctrl_t ctrl_reg;
	logic [AW-1:0] addr_reg;
	logic [DATA_W-1:0] wdata_reg;
	logic order_reg;

	// Access and burst state
	logic [AW-BURST_W-1:0] upper_reg;
	logic active_reg;
	logic rd_cycle_reg;

	// Sleep state
	logic [1:0] sleep_cnt_reg;
	logic [1:0] sleep_limit;
	logic asleep_reg;

	// Cycle decode
	logic sel_all;
	logic proc_seen;
	logic ctrl_seen;
	logic proc_start;
	logic ctrl_start;
	logic start;
	logic write_req;
	logic cont;
	logic step;
	logic do_write;
	logic read_cycle;

	// Array side
	logic [LANES-1:0] lane_we;
	logic [BURST_W-1:0] burst_addr;
	logic [AW-1:0] core_addr;
	logic [DATA_W-1:0] rdata;

	// Input registers, no reset needed on the datapath
	always_ff @(posedge i_clk) begin
		ctrl_reg <= i_ctrl;
		addr_reg <= i_addr;
		wdata_reg <= i_dq;
		order_reg <= i_burst_order;
	end

	// All three chip selects active
	always_comb begin
		sel_all = !ctrl_reg.first_chip_select_n &&
			ctrl_reg.second_chip_select &&
			!ctrl_reg.third_chip_select_n;
	end

	// Strobes as the device honours them
	always_comb begin
		// Processor strobe ignored while first select high
		proc_seen = !ctrl_reg.processor_addr_strobe_n &&
			!ctrl_reg.first_chip_select_n;
		// Controller strobe ignored while processor strobe low and first select low
		ctrl_seen = !ctrl_reg.controller_addr_strobe_n &&
			!proc_seen;
	end

	// Access start on either strobe, refused while asleep
	always_comb begin
		proc_start = proc_seen && sel_all;
		ctrl_start = ctrl_seen && sel_all;
		start = (proc_start || ctrl_start) && !asleep_reg;
	end

	// Write detect from global and lane inputs
	always_comb begin
		write_req = !ctrl_reg.global_write_n ||
			(!ctrl_reg.byte_write_enable_n &&
			!(&ctrl_reg.byte_lane_select_n));
	end

	// Burst continue: no honoured strobe, access still open
	always_comb begin
		cont = active_reg && !proc_seen &&
			ctrl_reg.controller_addr_strobe_n && !asleep_reg;
		step = cont && !ctrl_reg.burst_advance_n;
	end

	// Write cycles: immediate on controller start, else continue
	always_comb begin
		// Processor start: write inputs disregarded first cycle
		do_write = !asleep_reg && !proc_start && write_req &&
			(ctrl_start || cont);
	end

	// Read cycles: processor start always reads
	always_comb begin
		read_cycle = !asleep_reg && (start || cont) &&
			(proc_start || !write_req);
	end

	// Lane enables, global write overrides lane selects
	for (genvar l = 0; l < LANES; l++) begin : g_lane_we
		always_comb begin
			if (!do_write)
				lane_we[l] = 1'b0;
			else if (!ctrl_reg.global_write_n)
				lane_we[l] = 1'b1;
			else
				lane_we[l] = !ctrl_reg.byte_write_enable_n &&
					!ctrl_reg.byte_lane_select_n[l];
		end
	end

	// Access state, dropped on sleep entry
	always_ff @(posedge i_clk) begin
		if (i_sys_rst || asleep_reg) begin
			active_reg <= 1'b0;
		end else if (start) begin
			active_reg <= 1'b1;
		end
	end

	// Upper address held through the burst
	always_ff @(posedge i_clk) begin
		if (start)
			upper_reg <= addr_reg[AW-1:BURST_W];
	end

	// Low address bits walk through the burst counter
	burst_counter u_burst (
		.i_clk(i_clk),
		.i_load(start),
		.i_step(step),
		.i_interleaved(order_reg == ORDER_INTERLEAVED),
		.i_start(addr_reg[BURST_W-1:0]),
		.o_addr(burst_addr)
	);

	// Address to the array: external on start, internal otherwise
	always_comb begin
		if (start)
			core_addr = addr_reg;
		else
			core_addr = {upper_reg, burst_addr};
	end

	// Storage, read word registered inside the array
	sram_core #(.AW(AW)) u_core (
		.i_clk(i_clk),
		.i_lane_we(lane_we),
		.i_addr(core_addr),
		.i_wdata(wdata_reg),
		.o_rdata(rdata)
	);

	// Read cycle flag, lines up with the array read register
	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			rd_cycle_reg <= 1'b0;
		else
			rd_cycle_reg <= read_cycle;
	end

	// Flow-through: the array read register feeds the pins
	assign o_dq = rdata;

	// Output enable: masked during writes and sleep
	always_comb begin
		o_dq_oe_n = !(rd_cycle_reg && !i_output_enable_n &&
			!asleep_reg && !do_write);
	end

	// Cycles to wait: entry or exit count by direction
	always_comb begin
		if (i_sleep_request)
			sleep_limit = 2'(SLEEP_ENTER_CYC - 1);
		else
			sleep_limit = 2'(SLEEP_EXIT_CYC - 1);
	end

	// Sleep entry and exit; array contents untouched
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			sleep_cnt_reg <= SLEEP_CNT_ZERO;
			asleep_reg <= 1'b0;
		end else if (i_sleep_request != asleep_reg) begin
			if (sleep_cnt_reg == sleep_limit) begin
				asleep_reg <= i_sleep_request;
				sleep_cnt_reg <= SLEEP_CNT_ZERO;
			end else begin
				sleep_cnt_reg <= sleep_cnt_reg + 2'h1;
			end
		end else begin
			// Request withdrawn before the count ran out
			sleep_cnt_reg <= SLEEP_CNT_ZERO;
		end
	end

	// Sleep status straight from its register
	assign o_asleep = asleep_reg;
endmodule

// [tb/sram_port_asserts.sv]
// Pin timing checker for the burst SRAM port
module sram_port_asserts
	import sram_port_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// Watched pins
	input wire bus_ctrl_t i_ctrl,
	input wire logic i_output_enable_n,
	input wire logic i_sleep_request,
	input wire logic o_dq_oe_n,
	input wire logic o_asleep
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	// Decoded cycle kinds from the control bits
	wire logic [11:0] b = i_ctrl;
	wire logic wr = !b[5] || (!b[4] && b[3:0] != 4'hf);
	wire logic sel = b[11:9] == 3'h2;
	wire logic cw = sel && b[8] && !b[7] && wr;
	wire logic ps = sel && !b[8] && !i_sleep_request && !o_asleep;
	wire logic rd = b[8] && b[7] && !wr;
	wire logic ds = b[11] && !b[7];
	oe_mask_a: assert property (
		i_output_enable_n |-> o_dq_oe_n)
		else $error("data driven with output enable off");
	sleep_quiet_a: assert property (
		o_asleep |-> o_dq_oe_n)
		else $error("data driven while asleep");
	sleep_enter_a: assert property (
		i_sleep_request [*4] |-> o_asleep)
		else $error("sleep not entered in time");
	sleep_exit_a: assert property (
		!i_sleep_request [*4] |-> !o_asleep)
		else $error("sleep not left in time");
	sleep_delay_a: assert property (
		$rose(i_sleep_request) && !o_asleep |=> !o_asleep)
		else $error("sleep entered too early");
	write_float_a: assert property (
		cw |=> o_dq_oe_n)
		else $error("data driven during write");
	proc_read_a: assert property (
		ps ##1 rd ##1 !i_output_enable_n |-> !o_dq_oe_n)
		else $error("processor start gave no read");
	deselect_a: assert property (
		ds ##1 ds |=> o_dq_oe_n)
		else $error("data driven while deselected");
endmodule

bind sync_burst_sram_port sram_port_asserts i_sram_port_asserts (
	.i_clk(i_clk),
	.i_sys_rst(i_sys_rst),
	.i_ctrl(i_ctrl),
	.i_output_enable_n(i_output_enable_n),
	.i_sleep_request(i_sleep_request),
	.o_dq_oe_n(o_dq_oe_n),
	.o_asleep(o_asleep)
);

// [tb/host_model.sv]
// Host side model driving the synchronous SRAM bus
module host_model
	import sram_port_pkg::*;
(
	// Clock
	input wire logic i_clk,
	// Bus towards the SRAM port
	output bus_ctrl_t o_ctrl,
	output logic [ADDR_W-1:0] o_addr,
	output logic [DATA_W-1:0] o_dq,
	output logic o_output_enable_n,
	output logic o_sleep_request
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [DATA_W-1:0] wd = '0;
	logic drv = 1'b0;
	// Start deselected and awake
	initial begin
		o_ctrl = bus_ctrl_t'(12'hbff);
		o_addr = '0;
		o_output_enable_n = 1'b1;
		o_sleep_request = 1'b0;
	end
	// Released data lines show the inverse of the last value
	assign o_dq = drv ? wd : ~wd;
	// One bus cycle, driven just after the edge
	task automatic go(input logic [11:0] c, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d, input logic w);
		@(posedge i_clk);
		#1;
		o_ctrl = bus_ctrl_t'(c);
		o_addr = a;
		o_output_enable_n = w;
		if (w) begin
			wd = d;
		end
		drv = w;
	endtask
	// Sleep request, always from a deselected bus
	task automatic doze(input logic s);
		@(posedge i_clk);
		#1;
		o_ctrl = bus_ctrl_t'(12'hbff);
		o_sleep_request = s;
	endtask
endmodule

// [tb/testbench.sv]
// Self-checking bench for the burst SRAM port
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [17:0] B = 18'h00124;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic order = 1'b1;
	int fails = 0;
	int checked = 0;
	sram_port_pkg::bus_ctrl_t ctrl;
	logic [17:0] addr;
	logic [35:0] hdq, ddq;
	logic hoe_n, sleep, oe_n, asleep;
	// Shared data wire: device wins while it drives
	wire logic [35:0] dq = oe_n ? hdq : ddq;
	always #5 clk = ~clk;
	sync_burst_sram_port i_sync_burst_sram_port (
		.i_clk(clk),
		.i_sys_rst(rst),
		.i_ctrl(ctrl),
		.i_addr(addr),
		.i_burst_order(order),
		.i_output_enable_n(hoe_n),
		.i_sleep_request(sleep),
		.i_dq(dq),
		.o_dq(ddq),
		.o_dq_oe_n(oe_n),
		.o_asleep(asleep)
	);
	host_model i_host_model (
		.i_clk(clk),
		.o_ctrl(ctrl),
		.o_addr(addr),
		.o_dq(hdq),
		.o_output_enable_n(hoe_n),
		.o_sleep_request(sleep)
	);
	function automatic logic [35:0] dat(input logic [17:0] a);
		return {a, ~a};
	endfunction
	task automatic cmp(input string n, input logic [35:0] e, g);
		checked++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %h got %h", n, e, g);
		end
	endtask
	task automatic go(input logic [11:0] c, input logic [17:0] a,
		input logic [35:0] d, input logic w);
		i_host_model.go(c, a, d, w);
	endtask
	// Single access, word seen two edges after the start
	task automatic rd1(input logic [11:0] c, input logic [17:0] a,
		input logic [35:0] e);
		go(c, a, 36'h0, 1'b0);
		go(12'hbff, a, 36'h0, 1'b0);
		go(12'hbff, a, 36'h0, 1'b0);
		cmp("read", e, ddq);
		cmp("drive", 36'h0, {35'h0, oe_n});
	endtask
	// Four-word burst, upper address pins scrambled meanwhile
	task automatic t_burst(input logic [11:0] c, input logic [1:0] s,
		input logic [7:0] q);
		go(c, B + s, 36'h0, 1'b0);
		for (int k = 0; k < 5; k++) begin
			go(k < 3 ? 12'h5bf : 12'hbff, ~B, 36'h0, 1'b0);
			if (k > 0) begin
				cmp("burst", dat({B[17:2], q[2*k-2 +: 2]}), ddq);
			end
		end
	endtask
	task automatic t_fill;
		for (int i = 0; i < 4; i++) begin
			go(12'h55f, B + i, dat(B + i), 1'b1);
		end
		rd1(12'h57f, B + 2, dat(B + 2));
	endtask
	task automatic t_pwrite;
		go(12'h4df, B + 3, 36'h0, 1'b0);
		go(12'h5df, B, 36'h0a5a5a5a5, 1'b1);
		rd1(12'h57f, B + 3, 36'h0a5a5a5a5);
		go(12'h565, B + 3, 36'h0, 1'b1);
		rd1(12'h57f, B + 3, 36'h0a5a5a5a5 & 36'h007fc01ff);
	endtask
	task automatic t_sleep;
		i_host_model.doze(1'b1);
		repeat (4) go(12'hbff, B, 36'h0, 1'b0);
		cmp("asleep", 36'h1, {35'h0, asleep});
		i_host_model.doze(1'b0);
		repeat (4) go(12'hbff, B, 36'h0, 1'b0);
		cmp("asleep", 36'h0, {35'h0, asleep});
		rd1(12'h57f, B, dat(B));
	endtask
	task automatic conclude;
		if (fails == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (5) @(posedge clk);
		#1;
		rst = 1'b0;
		go(12'hb7f, B, 36'h0, 1'b0);
		go(12'hb7f, B, 36'h0, 1'b0);
		t_fill;
		t_burst(12'h4ff, 2'h1, 8'hb1);
		order = 1'b0;
		t_burst(12'h57f, 2'h3, 8'h93);
		rd1(12'hcff, B + 1, dat(B + 2));
		rd1(12'h45f, B + 1, dat(B + 1));
		t_pwrite;
		t_sleep;
		conclude;
	end
endmodule
